// file: inc/bmpc_pkg.sv
package bmpc_pkg;

    // timing base
    localparam int CLK_PERIOD_NS     = 50;
    localparam int CLK_FREQ_HZ       = 20000000;

    // burst timer: fixed 52 kHz, duty limit 50 %
    localparam int BURST_TIMER_FREQ_HZ = 52000;
    localparam int BURST_MAX_DUTY_PCT  = 50;
    localparam int BURST_PERIOD_CYC    = CLK_FREQ_HZ / BURST_TIMER_FREQ_HZ;
    localparam int BURST_ON_MAX_CYC    = (BURST_PERIOD_CYC * BURST_MAX_DUTY_PCT) / 100;

    // qualification and limit times
    localparam int VCC_OVP_NS        = 10000;
    localparam int VCC_OVP_CYC       = (VCC_OVP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OVERLOAD_BLANK_MS = 30;
    localparam int OVERLOAD_BLANK_CYC = OVERLOAD_BLANK_MS * (CLK_FREQ_HZ / 1000);
    localparam int OUTPUT_OVP_BLANK_NS = 100000;
    localparam int OUTPUT_OVP_BLANK_CYC =
        (OUTPUT_OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_WINDING_BLANK_NS = 190;
    localparam int SHORT_WINDING_BLANK_CYC =
        (SHORT_WINDING_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_ON_TIME_NS    = 30000;
    localparam int MAX_ON_TIME_CYC   = MAX_ON_TIME_NS / CLK_PERIOD_NS;

    localparam int QUAL_W            = 20;
    localparam int BTMR_W            = 9;
    localparam int ONCNT_W           = 10;

    // valley counter load value on burst exit
    localparam logic [3:0] VALLEY_LOAD_VALUE = 4'h1;

    // register map (byte addresses)
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK   = 8'h04;
    localparam logic [7:0] ADDR_STATE  = 8'h08;

    // event bit positions
    localparam int EV_VCC_OV    = 0;
    localparam int EV_VCC_UV    = 1;
    localparam int EV_OVERLOAD  = 2;
    localparam int EV_OVERTEMP  = 3;
    localparam int EV_OUT_OVP   = 4;
    localparam int EV_SHORT_WND = 5;
    localparam int EV_MAX_ON    = 6;
    localparam int EV_BURST_EXIT = 7;
    localparam int EV_W         = 8;

    localparam logic [EV_W-1:0] STATUS_RST = 8'h00;
    localparam logic [EV_W-1:0] MASK_RST   = 8'h00;

    typedef enum logic [1:0] {
        ST_CHARGE,
        ST_RUN,
        ST_AUTORESTART,
        ST_LATCHED
    } bmpc_state_t;

    // comparator indications from the power stage
    typedef struct packed {
        logic fb_above_burst_on;
        logic fb_below_burst_off;
        logic fb_above_leave_burst;
        logic cs_burst_limit;
        logic cs_short_winding;
        logic zc_output_ovp;
        logic vcc_over;
        logic vcc_below_off;
        logic vcc_above_on;
        logic vcc_below_pd;
        logic overtemp;
    } bmpc_cmp_t;

    localparam int CMP_W = $bits(bmpc_cmp_t);
    localparam logic [CMP_W-1:0] CMP_RST = 11'h000;

endpackage : bmpc_pkg

// file: hdl/bmpc_qual.sv
`timescale 1ns/100ps
module bmpc_qual #(
    parameter int COUNT = 4
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // indication
    input  wire logic level,
    input  wire logic enable,
    output logic      hit
);
    import bmpc_pkg::*;

    logic [QUAL_W-1:0] cnt_reg;

    // counter restarts as soon as the indication drops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (!(level && enable)) begin
            cnt_reg <= '0;
        end else if (cnt_reg != QUAL_W'(COUNT)) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign hit = level && enable && (cnt_reg == QUAL_W'(COUNT - 1));

endmodule : bmpc_qual

// file: hdl/bmpc_ctrl.sv
`timescale 1ns/100ps
// Operation
// - in halted burst, feedback above burst-on level re-enables bias and switching
// - burst turn-on comes from a fixed 52 kHz timer
// - burst on-pulse ends when current sense reaches burst limit
// - burst on-pulse ends at half the burst timer period
// - first of current limit or duty limit clears the gate flip-flop
// - feedback at burst-off level resets bias, halts switching until burst-on
// - feedback above leave-burst level exits burst, restoring full current limit
// - valley counter loaded with one immediately on burst exit
// - supply under/over-voltage resets, gate off, recharge, restart with soft-start
// - supply over-voltage for 10 us triggers auto restart, normal mode only
// - overload indication lasting 30 ms enters auto restart
// - overload timer inhibited in burst mode
// - output over-voltage during off-time for 100 us latches off
// - latch released only when supply falls below power-down level
// - over-temperature gives auto restart, ignored in burst mode
// - short-winding during on-time for 190 ns latches off, not in burst
// - latched: startup cell cycles between off and on levels, no switching
// - gate high past maximum on-time is forced off at once
module bmpc_ctrl #(
    parameter int OVERLOAD_CYC = bmpc_pkg::OVERLOAD_BLANK_CYC
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // power stage comparators
    input  wire bmpc_pkg::bmpc_cmp_t cmp_i,
    // mode and normal switching requests
    input  wire logic              burst_enter,
    input  wire logic              normal_turn_on,
    input  wire logic              normal_turn_off,
    // power stage controls
    output logic                   gate_drive,
    output logic                   bias_en,
    output logic                   startup_en,
    output logic                   soft_start,
    output logic                   burst_mode,
    output logic                   full_current_limit,
    output logic                   valley_load,
    output logic      [3:0]        valley_load_value,
    // interrupt
    output logic                   irq
);
    import bmpc_pkg::*;

    logic [CMP_W-1:0]  meta_reg;
    logic [CMP_W-1:0]  sync_reg;
    bmpc_cmp_t         cmp;
    bmpc_state_t       state_reg;
    logic              gate_reg;
    logic              burst_reg;
    logic              active_reg;
    logic              startup_reg;
    logic              soft_reg;
    logic              valley_reg;
    logic [BTMR_W-1:0] btmr_reg;
    logic [ONCNT_W-1:0] on_cnt_reg;
    logic [EV_W-1:0]   status_reg;
    logic [EV_W-1:0]   status_next;
    logic [EV_W-1:0]   mask_reg;
    logic [EV_W-1:0]   ev;
    logic [31:0]       rdata_reg;
    logic              ack_reg;
    logic              run;
    logic              hit_vcc_ov;
    logic              hit_olp;
    logic              hit_ovp;
    logic              hit_sw;
    logic              uv_fault;
    logic              otp_fault;
    logic              ar_fault;
    logic              latch_fault;
    logic              leave_burst;
    logic              burst_set;
    logic              burst_cs_off;
    logic              burst_duty_off;
    logic              max_on;
    logic              gate_set;
    logic              gate_clr;
    logic              wr;
    logic              rd;

    // two flops on every comparator before use
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= CMP_RST;
            sync_reg <= CMP_RST;
        end else begin
            meta_reg <= cmp_i;
            sync_reg <= meta_reg;
        end
    end

    assign cmp = bmpc_cmp_t'(sync_reg);
    assign run = (state_reg == ST_RUN);

    // qualification timers
    bmpc_qual #(.COUNT(VCC_OVP_CYC)) u_vcc_ov (
        .core_clk (core_clk),
        .rst      (rst),
        .level    (cmp.vcc_over),
        .enable   (run && !burst_reg),
        .hit      (hit_vcc_ov)
    );

    bmpc_qual #(.COUNT(OVERLOAD_CYC)) u_olp (
        .core_clk (core_clk),
        .rst      (rst),
        .level    (cmp.fb_above_leave_burst),
        .enable   (run && !burst_reg),
        .hit      (hit_olp)
    );

    bmpc_qual #(.COUNT(OUTPUT_OVP_BLANK_CYC)) u_ovp (
        .core_clk (core_clk),
        .rst      (rst),
        .level    (cmp.zc_output_ovp),
        .enable   (run && !gate_reg),
        .hit      (hit_ovp)
    );

    bmpc_qual #(.COUNT(SHORT_WINDING_BLANK_CYC)) u_sw (
        .core_clk (core_clk),
        .rst      (rst),
        .level    (cmp.cs_short_winding),
        .enable   (run && gate_reg && !burst_reg),
        .hit      (hit_sw)
    );

    assign uv_fault    = run && cmp.vcc_below_off;
    assign otp_fault   = run && !burst_reg && cmp.overtemp;
    assign ar_fault    = hit_vcc_ov || hit_olp || uv_fault || otp_fault;
    assign latch_fault = hit_ovp || hit_sw;

    // protection state; latch beats auto restart
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_CHARGE;
        end else begin
            case (state_reg)
                ST_CHARGE: begin
                    if (cmp.vcc_above_on) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (latch_fault) begin
                        state_reg <= ST_LATCHED;
                    end else if (ar_fault) begin
                        state_reg <= ST_AUTORESTART;
                    end
                end
                ST_AUTORESTART: begin
                    if (cmp.vcc_below_off) begin
                        state_reg <= ST_CHARGE;
                    end
                end
                ST_LATCHED: begin
                    if (cmp.vcc_below_pd) begin
                        state_reg <= ST_CHARGE;
                    end
                end
                default: begin
                    state_reg <= ST_CHARGE;
                end
            endcase
        end
    end

    // startup cell control
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            startup_reg <= 1'b1;
        end else if (state_reg == ST_RUN) begin
            startup_reg <= 1'b0;
        end else if (cmp.vcc_below_off) begin
            startup_reg <= 1'b1;
        end else if (cmp.vcc_above_on) begin
            startup_reg <= 1'b0;
        end
    end

    // soft-start pulse on every restart
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            soft_reg <= 1'b0;
        end else begin
            soft_reg <= (state_reg == ST_CHARGE) && cmp.vcc_above_on;
        end
    end

    // burst mode flag
    assign leave_burst = burst_reg && cmp.fb_above_leave_burst;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            burst_reg <= 1'b0;
        end else if (!run || leave_burst) begin
            burst_reg <= 1'b0;
        end else if (burst_enter) begin
            burst_reg <= 1'b1;
        end
    end

    // valley counter load strobe, same cycle burst clears
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            valley_reg <= 1'b0;
        end else begin
            valley_reg <= run && leave_burst;
        end
    end

    // hysteretic bias on/off inside burst
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            active_reg <= 1'b0;
        end else if (!burst_reg) begin
            active_reg <= 1'b0;
        end else if (cmp.fb_above_burst_on) begin
            active_reg <= 1'b1;
        end else if (cmp.fb_below_burst_off) begin
            active_reg <= 1'b0;
        end
    end

    // burst timer runs only while burst is active, held at zero while halted, wraps each period
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            btmr_reg <= '0;
        end else if (!active_reg || btmr_reg == BTMR_W'(BURST_PERIOD_CYC - 1)) begin
            btmr_reg <= '0;
        end else begin
            btmr_reg <= btmr_reg + 1'b1;
        end
    end

    // max on-time counter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            on_cnt_reg <= '0;
        end else if (!gate_reg) begin
            on_cnt_reg <= '0;
        end else begin
            on_cnt_reg <= on_cnt_reg + 1'b1;
        end
    end

    assign burst_set      = active_reg && btmr_reg == '0;
    assign burst_cs_off   = burst_reg && cmp.cs_burst_limit;
    assign burst_duty_off = burst_reg && btmr_reg >= BTMR_W'(BURST_ON_MAX_CYC);
    assign max_on         = on_cnt_reg >= ONCNT_W'(MAX_ON_TIME_CYC - 1);
    assign gate_set       = run && (burst_reg ? burst_set : normal_turn_on);
    assign gate_clr       = !run || burst_cs_off || burst_duty_off || max_on || latch_fault
                            || ar_fault || (burst_reg && !active_reg)
                            || (!burst_reg && normal_turn_off);

    // clear has priority: any turn-off reason wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_reg <= 1'b0;
        end else if (gate_clr) begin
            gate_reg <= 1'b0;
        end else if (gate_set) begin
            gate_reg <= 1'b1;
        end
    end

    assign gate_drive         = gate_reg;
    assign bias_en            = run && (!burst_reg || active_reg);
    assign startup_en         = startup_reg;
    assign soft_start         = soft_reg;
    assign burst_mode         = burst_reg;
    assign full_current_limit = !burst_reg;
    assign valley_load        = valley_reg;
    assign valley_load_value  = VALLEY_LOAD_VALUE;

    // events
    always_comb begin
        ev = '0;
        ev[EV_VCC_OV]     = run && hit_vcc_ov;
        ev[EV_VCC_UV]     = uv_fault;
        ev[EV_OVERLOAD]   = run && hit_olp;
        ev[EV_OVERTEMP]   = otp_fault;
        ev[EV_OUT_OVP]    = run && hit_ovp;
        ev[EV_SHORT_WND]  = run && hit_sw;
        ev[EV_MAX_ON]     = gate_reg && max_on;
        ev[EV_BURST_EXIT] = run && leave_burst;
    end

    // wishbone: one wait state, ack drops the cycle after
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
        end
    end

    // write-one-to-clear; a new event beats the clear
    always_comb begin
        status_next = status_reg;
        if (wr && wb_sel_i[0] && wb_adr_i == ADDR_STATUS) begin
            status_next = status_reg & ~wb_dat_i[EV_W-1:0];
        end
        status_next = status_next | ev;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_reg <= STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mask_reg <= MASK_RST;
        end else if (wr && wb_sel_i[0] && wb_adr_i == ADDR_MASK) begin
            mask_reg <= wb_dat_i[EV_W-1:0];
        end
    end

    // unmapped reads return zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (rd) begin
            if (wb_adr_i == ADDR_STATUS) begin
                rdata_reg <= {24'h000000, status_reg};
            end else if (wb_adr_i == ADDR_MASK) begin
                rdata_reg <= {24'h000000, mask_reg};
            end else if (wb_adr_i == ADDR_STATE) begin
                rdata_reg <= {24'h000000, startup_reg, bias_en, active_reg, burst_reg,
                              gate_reg, 1'b0, state_reg};
            end else begin
                rdata_reg <= '0;
            end
        end
    end

    assign wb_dat_o = rdata_reg;
    assign wb_ack_o = ack_reg;
    assign irq      = |(status_reg & mask_reg);

    // checks
    AST_BURST_ON_TIMER: assert property (@(posedge core_clk) disable iff (rst)
        $rose(gate_reg) && burst_reg |-> $past(btmr_reg) == '0)
        else $error("burst turn-on not aligned to timer");

    AST_BURST_CS_OFF: assert property (@(posedge core_clk) disable iff (rst)
        gate_reg && burst_reg && cmp.cs_burst_limit |=> !gate_reg)
        else $error("burst current limit did not end pulse");

    AST_BURST_DUTY: assert property (@(posedge core_clk) disable iff (rst)
        gate_reg && burst_reg |-> btmr_reg <= BTMR_W'(BURST_ON_MAX_CYC))
        else $error("burst on-time exceeded half period");

    AST_BURST_HALT: assert property (@(posedge core_clk) disable iff (rst)
        burst_reg && !active_reg |=> !gate_reg)
        else $error("switching while burst halted");

    AST_BURST_RESUME: assert property (@(posedge core_clk) disable iff (rst)
        burst_reg && run && cmp.fb_above_burst_on && !leave_burst |=> active_reg && bias_en)
        else $error("burst did not resume above burst-on level");

    AST_LEAVE_BURST: assert property (@(posedge core_clk) disable iff (rst)
        run && leave_burst |=> !burst_reg && full_current_limit && valley_load)
        else $error("burst exit or valley load missing");

    AST_VCC_OV_BURST: assert property (@(posedge core_clk) disable iff (rst)
        burst_reg |-> !hit_vcc_ov && !hit_olp && !otp_fault)
        else $error("normal-only protection acted in burst");

    AST_OLP_AR: assert property (@(posedge core_clk) disable iff (rst)
        run && hit_olp && !latch_fault |=> state_reg == ST_AUTORESTART && !gate_reg)
        else $error("overload did not enter auto restart");

    AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == ST_LATCHED && !cmp.vcc_below_pd |=> state_reg == ST_LATCHED)
        else $error("latch released early");

    AST_LATCH_NO_GATE: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == ST_LATCHED |-> !gate_reg)
        else $error("switching while latched");

    AST_MAX_ON: assert property (@(posedge core_clk) disable iff (rst)
        gate_reg |-> on_cnt_reg < ONCNT_W'(MAX_ON_TIME_CYC))
        else $error("gate exceeded maximum on-time");

    AST_SW_LATCH: assert property (@(posedge core_clk) disable iff (rst)
        run && gate_reg && !burst_reg && cmp.cs_short_winding [*4] |=> state_reg == ST_LATCHED)
        else $error("short winding did not latch");

endmodule : bmpc_ctrl

// file: testbench/bmpc_stage_model.sv
`timescale 1ns/100ps
module bmpc_stage_model (
    // clock
    input  wire logic                core_clk,
    // gate and bench-set levels
    input  wire logic                gate_drive,
    input  wire bmpc_pkg::bmpc_cmp_t lv,
    input  wire logic [15:0]         cs_dly,
    // comparator levels to the block
    output bmpc_pkg::bmpc_cmp_t      cmp_o
);
    import bmpc_pkg::*;

    logic [15:0] on_cnt;

    // shunt ramps only while the switch conducts
    always_ff @(posedge core_clk) begin
        on_cnt <= gate_drive ? on_cnt + 16'h0001 : 16'h0000;
    end

    always_comb begin
        cmp_o = lv;
        cmp_o.cs_burst_limit = gate_drive && (on_cnt >= cs_dly);
    end
endmodule : bmpc_stage_model

// file: testbench/bmpc_ctrl_tb_top.sv
`timescale 1ns/100ps
module bmpc_ctrl_tb_top;
    import bmpc_pkg::*;

    // short overload blank keeps the run brief
    localparam int OVL = 50;

    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    bmpc_cmp_t   lv       = '0;
    bmpc_cmp_t   cmp;
    logic [15:0] cs_dly   = 16'hFFFF;
    logic        burst_enter = 1'b0;
    logic        normal_turn_on = 1'b0;
    logic        normal_turn_off = 1'b0;
    logic        gate_drive, bias_en, startup_en, soft_start;
    logic        burst_mode, fcl, valley_load, irq;
    logic [3:0]  vlv;
    logic [31:0] d;
    int          n_fail = 0;
    int          tests_run = 0;
    int          n_soft = 0;
    int          t, w;

    always #25 core_clk = ~core_clk;

    // one pulse expected per restart
    always @(negedge core_clk) begin
        if (soft_start === 1'b1) n_soft++;
    end

    bmpc_ctrl #(.OVERLOAD_CYC(OVL)) bmpc_ctrl_i (
        .core_clk(core_clk), .rst(rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_i(cmp),
        .burst_enter(burst_enter), .normal_turn_on(normal_turn_on),
        .normal_turn_off(normal_turn_off), .gate_drive(gate_drive),
        .bias_en(bias_en), .startup_en(startup_en), .soft_start(soft_start),
        .burst_mode(burst_mode), .full_current_limit(fcl),
        .valley_load(valley_load), .valley_load_value(vlv), .irq(irq));

    bmpc_stage_model bmpc_stage_model_i (
        .core_clk(core_clk), .gate_drive(gate_drive), .lv(lv),
        .cs_dly(cs_dly), .cmp_o(cmp));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // one classic cycle; held until ack is sampled high at a rising edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= wd;
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1 && k < 20) begin
            @(posedge core_clk);
            k++;
        end
        if (k >= 20) chk(wb_ack_o, 1);
        d = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    // low cycles before the next gate pulse, then its width
    task automatic pulse_w(output int lo, output int hi);
        lo = 0;
        hi = 0;
        while (gate_drive !== 1'b1 && lo < 2000) begin
            @(negedge core_clk);
            lo++;
        end
        while (gate_drive === 1'b1 && hi < 2000) begin
            @(negedge core_clk);
            hi++;
        end
    endtask : pulse_w

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    initial begin
        tick(60000);
        n_fail++;
        wrap_up();
    end

    initial begin
        tick(5);
        rst <= 1'b0;
        tick(2);
        chk(gate_drive, 0);
        chk(startup_en, 1);
        wb(0, ADDR_STATUS, 0);
        chk(d, {24'h0, STATUS_RST});
        wb(0, ADDR_MASK, 0);
        chk(d, {24'h0, MASK_RST});
        wb(0, 8'h3C, 0);
        chk(d, 0);
        wb(1, ADDR_MASK, 32'hFF);
        wb(1, ADDR_STATE, 32'hFF);
        wb(0, ADDR_STATE, 0);
        chk(d[1:0], 0);
        $display("test registers done");
        lv.vcc_above_on <= 1'b1;
        tick(6);
        lv.vcc_above_on <= 1'b0;
        wb(0, ADDR_STATE, 0);
        chk(d[1:0], 1);
        normal_turn_on <= 1'b1;
        tick(1);
        normal_turn_on <= 1'b0;
        pulse_w(t, w);
        chk(w <= MAX_ON_TIME_CYC && w >= MAX_ON_TIME_CYC - 3, 1);
        wb(0, ADDR_STATUS, 0);
        chk(d[EV_MAX_ON], 1);
        @(negedge core_clk);
        chk(irq, 1);
        wb(1, ADDR_STATUS, 32'hFF);
        @(negedge core_clk);
        chk(irq, 0);
        $display("test max on-time done");
        tick(1);
        burst_enter <= 1'b1;
        tick(1);
        burst_enter <= 1'b0;
        lv.fb_above_burst_on <= 1'b1;
        pulse_w(t, w);
        pulse_w(t, w);
        chk(w, BURST_ON_MAX_CYC);
        chk(t + w, BURST_PERIOD_CYC);
        chk(fcl, 0);
        tick(1);
        cs_dly <= 16'd20;
        // overtemp in burst must not stop switching
        lv.overtemp <= 1'b1;
        pulse_w(t, w);
        chk(w >= 20 && w <= 30, 1);
        tick(1);
        lv.overtemp <= 1'b0;
        lv.fb_above_burst_on <= 1'b0;
        lv.fb_below_burst_off <= 1'b1;
        tick(5);
        lv.fb_below_burst_off <= 1'b0;
        pulse_w(t, w);
        chk(w, 0);
        chk(bias_en, 0);
        tick(1);
        lv.fb_above_burst_on <= 1'b1;
        pulse_w(t, w);
        chk(w > 0 && t < BURST_PERIOD_CYC + 10, 1);
        chk(bias_en, 1);
        tick(1);
        lv.fb_above_leave_burst <= 1'b1;
        t = 0;
        while (valley_load !== 1'b1 && t < 10) begin
            @(negedge core_clk);
            t++;
        end
        chk(valley_load, 1);
        chk(vlv, VALLEY_LOAD_VALUE);
        @(negedge core_clk);
        chk(burst_mode, 0);
        chk(fcl, 1);
        $display("test burst done");
        tick(OVL + 20);
        wb(0, ADDR_STATE, 0);
        chk(d[1:0], 2);
        chk(gate_drive, 0);
        lv.fb_above_leave_burst <= 1'b0;
        lv.fb_above_burst_on <= 1'b0;
        lv.vcc_below_off <= 1'b1;
        tick(6);
        chk(startup_en, 1);
        lv.vcc_below_off <= 1'b0;
        lv.vcc_above_on <= 1'b1;
        tick(6);
        lv.vcc_above_on <= 1'b0;
        wb(0, ADDR_STATE, 0);
        chk(d[1:0], 1);
        for (int i = 0; i < 3; i++) begin
            lv.zc_output_ovp <= 1'b1;
            tick(i < 2 ? OUTPUT_OVP_BLANK_CYC - 500 : OUTPUT_OVP_BLANK_CYC + 10);
            lv.zc_output_ovp <= 1'b0;
            tick(2);
            wb(0, ADDR_STATE, 0);
            chk(d[1:0], i < 2 ? 1 : 3);
        end
        lv.vcc_below_off <= 1'b1;
        tick(6);
        chk(startup_en, 1);
        lv.vcc_below_off <= 1'b0;
        lv.vcc_above_on <= 1'b1;
        tick(6);
        chk(startup_en, 0);
        chk(gate_drive, 0);
        lv.vcc_above_on <= 1'b0;
        wb(0, ADDR_STATE, 0);
        chk(d[1:0], 3);
        lv.vcc_below_pd <= 1'b1;
        tick(6);
        lv.vcc_below_pd <= 1'b0;
        wb(0, ADDR_STATE, 0);
        chk(d[1:0], 0);
        $display("test latch done");
        lv.vcc_above_on <= 1'b1;
        tick(6);
        lv.vcc_above_on <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            lv.vcc_over <= 1'b1;
            tick(i == 0 ? VCC_OVP_CYC - 50 : VCC_OVP_CYC + 10);
            lv.vcc_over <= 1'b0;
            tick(2);
            wb(0, ADDR_STATE, 0);
            chk(d[1:0], i == 0 ? 1 : 2);
        end
        wb(0, ADDR_STATUS, 0);
        chk(d[EV_VCC_OV], 1);
        $display("test supply over-voltage done");
        lv.vcc_below_off <= 1'b1;
        tick(6);
        lv.vcc_below_off <= 1'b0;
        lv.vcc_above_on <= 1'b1;
        tick(6);
        lv.vcc_above_on <= 1'b0;
        normal_turn_on <= 1'b1;
        tick(1);
        normal_turn_on <= 1'b0;
        lv.cs_short_winding <= 1'b1;
        tick(8);
        lv.cs_short_winding <= 1'b0;
        wb(0, ADDR_STATE, 0);
        chk(d[1:0], 3);
        chk(gate_drive, 0);
        chk(n_soft, 4);
        $display("test short winding done");
        wrap_up();
    end
endmodule : bmpc_ctrl_tb_top
